// file: src/rtcx_params.svh
`ifndef RTCX_PARAMS_SVH
`define RTCX_PARAMS_SVH

// Register indices; the byte address is four times the index.
`define RTCX_IDX_CAPTURE0 8'h00
`define RTCX_IDX_CAPTURE3 8'h03
`define RTCX_IDX_CTRL 8'h04
`define RTCX_IDX_OSC_CTRL 8'h05
`define RTCX_IDX_OSC_CFG 8'h06
`define RTCX_IDX_ALARM 8'h08
`define RTCX_IDX_INT_STATUS 8'h10
`define RTCX_IDX_INT_MASK 8'h11

// Clock control bits.
`define RTCX_CTRL_RUN_BIT 4
`define RTCX_CTRL_ALARM_EN_BIT 3
`define RTCX_CTRL_ALARM_BIT 2
`define RTCX_CTRL_LOAD_BIT 1
`define RTCX_CTRL_SNAP_BIT 0

// Oscillator control bits.
`define RTCX_XCN_GAIN_BIT 7
`define RTCX_XCN_MODE_BIT 6
`define RTCX_XCN_BIAS_BIT 5
`define RTCX_XCN_VALID_BIT 4
`define RTCX_XCN_RESET 8'h00

// Oscillator configuration fields.
`define RTCX_XCF_STEP_BIT 7
`define RTCX_XCF_READY_BIT 6
`define RTCX_XCF_CAP_MSB 3
`define RTCX_XCF_CAP_RESET 4'h0

// Interrupt status bits.
`define RTCX_INT_ALARM_BIT 0
`define RTCX_INT_LOAD_BIT 1
`define RTCX_INT_SNAP_BIT 2
`define RTCX_INT_W 3

// Timing: the slow clock period in ps and the system clock period in ps.
`define RTCX_SLOW_PERIOD_PS 30517578
`define RTCX_PCLK_PERIOD_PS 10000
`define RTCX_SLOW_DIV ((`RTCX_SLOW_PERIOD_PS + `RTCX_PCLK_PERIOD_PS - 1) / `RTCX_PCLK_PERIOD_PS)

`endif

// file: src/rtcx_pkg.sv
package rtcx_pkg;

    typedef logic [7:0] rtcx_byte_t;

    typedef enum logic [2:0] {
        RTCX_SEL_NONE,
        RTCX_SEL_CAPTURE,
        RTCX_SEL_CTRL,
        RTCX_SEL_OSC_CTRL,
        RTCX_SEL_OSC_CFG,
        RTCX_SEL_ALARM,
        RTCX_SEL_INT_STATUS,
        RTCX_SEL_INT_MASK
    } rtcx_sel_e;

endpackage

// file: src/rtcx_tick_div.sv
`timescale 1ns/1ps

// Produces a one-cycle enable pulse once every DIV clock cycles.
module rtcx_tick_div #(
    parameter int DIV = 3052
) (
    input wire logic pclk,
    input wire logic presetn,
    output logic tick
);
    logic [15:0] cnt_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 16'h0000;
            tick <= 1'b0;
        end else if (cnt_r == 16'(DIV - 1)) begin
            cnt_r <= 16'h0000;
            tick <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 16'h0001;
            tick <= 1'b0;
        end
    end
endmodule

// file: src/rtcx_ctrl.sv
// Operation
// - alarm bit reads flag, write sets auto-reset
// - writing 1 starts timer load, hardware clears
// - writing 1 starts snapshot, hardware clears
// - alarm flag lasts at most one slow cycle
// - oscillator control bit 7 enables gain control
// - bit 6 selects crystal or self-oscillate
// - bit 5 enables bias doubling
// - bit 4 reads oscillation amplitude valid
// - oscillator control bits 3:0 read zero
// - configuration bit 7 enables load-cap stepping
// - bit 6 reads one once cap reached
// - configuration bits 5:4 read zero
// - bits 3:0 hold load-cap target
// - load copies bytes to timer; snapshot reverse
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`include "rtcx_params.svh"

module rtcx_ctrl #(
    parameter int SLOW_DIV = `RTCX_SLOW_DIV,
    parameter int TIMER_W = 32,
    parameter logic [3:0] LOAD_CAP_RESET = `RTCX_XCF_CAP_RESET
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic osc_amp_ok,
    output logic osc_gain_ctrl_enable,
    output logic osc_mode_select,
    output logic osc_bias_double,
    output logic [3:0] load_cap_now,
    output logic alarm_event_flag,
    output logic irq
);
    logic slow_tick;
    logic [7:0] idx;
    rtcx_pkg::rtcx_sel_e sel;
    logic setup_ph;
    logic wr_en;
    logic rd_en;
    logic [31:0] rdata_nxt;

    logic [TIMER_W-1:0] timer_r;
    logic [TIMER_W-1:0] alarm_r;
    rtcx_pkg::rtcx_byte_t capture_r [4];
    logic run_r;
    logic alarm_en_r;
    logic auto_reset_r;
    logic load_req_r;
    logic snap_req_r;
    logic [3:0] load_cap_value_r;
    logic load_cap_autostep_r;
    logic osc_valid_r;
    logic [`RTCX_INT_W-1:0] int_status_r;
    logic [`RTCX_INT_W-1:0] int_mask_r;
    logic [`RTCX_INT_W-1:0] int_set;
    logic alarm_hit;

    rtcx_tick_div #(
        .DIV(SLOW_DIV)
    ) u_div (
        .pclk(pclk),
        .presetn(presetn),
        .tick(slow_tick)
    );

    // Word-aligned decode; the low two address bits are ignored.
    assign idx = paddr[9:2];
    assign setup_ph = psel && !penable;
    assign wr_en = psel && penable && pready && pwrite && !pslverr;
    assign rd_en = psel && penable && pready && !pwrite && !pslverr;

    always_comb begin
        sel = rtcx_pkg::RTCX_SEL_NONE;
        if (paddr[11:10] == 2'b00) begin
            if (idx <= `RTCX_IDX_CAPTURE3) begin
                sel = rtcx_pkg::RTCX_SEL_CAPTURE;
            end else if (idx == `RTCX_IDX_CTRL) begin
                sel = rtcx_pkg::RTCX_SEL_CTRL;
            end else if (idx == `RTCX_IDX_OSC_CTRL) begin
                sel = rtcx_pkg::RTCX_SEL_OSC_CTRL;
            end else if (idx == `RTCX_IDX_OSC_CFG) begin
                sel = rtcx_pkg::RTCX_SEL_OSC_CFG;
            end else if (idx == `RTCX_IDX_ALARM) begin
                sel = rtcx_pkg::RTCX_SEL_ALARM;
            end else if (idx == `RTCX_IDX_INT_STATUS) begin
                sel = rtcx_pkg::RTCX_SEL_INT_STATUS;
            end else if (idx == `RTCX_IDX_INT_MASK) begin
                sel = rtcx_pkg::RTCX_SEL_INT_MASK;
            end
        end
    end

    always_comb begin
        rdata_nxt = 32'h0000_0000;
        unique case (sel)
            rtcx_pkg::RTCX_SEL_NONE: begin
                rdata_nxt = 32'h0000_0000;
            end
            rtcx_pkg::RTCX_SEL_CAPTURE: begin
                rdata_nxt[7:0] = capture_r[idx[1:0]];
            end
            rtcx_pkg::RTCX_SEL_CTRL: begin
                rdata_nxt[`RTCX_CTRL_RUN_BIT] = run_r;
                rdata_nxt[`RTCX_CTRL_ALARM_EN_BIT] = alarm_en_r;
                rdata_nxt[`RTCX_CTRL_ALARM_BIT] = alarm_event_flag;
                rdata_nxt[`RTCX_CTRL_LOAD_BIT] = load_req_r;
                rdata_nxt[`RTCX_CTRL_SNAP_BIT] = snap_req_r;
            end
            rtcx_pkg::RTCX_SEL_OSC_CTRL: begin
                rdata_nxt[`RTCX_XCN_GAIN_BIT] = osc_gain_ctrl_enable;
                rdata_nxt[`RTCX_XCN_MODE_BIT] = osc_mode_select;
                rdata_nxt[`RTCX_XCN_BIAS_BIT] = osc_bias_double;
                rdata_nxt[`RTCX_XCN_VALID_BIT] = osc_valid_r;
                rdata_nxt[3:0] = 4'h0;
            end
            rtcx_pkg::RTCX_SEL_OSC_CFG: begin
                rdata_nxt[`RTCX_XCF_STEP_BIT] = load_cap_autostep_r;
                rdata_nxt[`RTCX_XCF_READY_BIT] = (load_cap_now == load_cap_value_r);
                rdata_nxt[5:4] = 2'b00;
                rdata_nxt[`RTCX_XCF_CAP_MSB:0] = load_cap_value_r;
            end
            rtcx_pkg::RTCX_SEL_ALARM: begin
                rdata_nxt[TIMER_W-1:0] = alarm_r;
            end
            rtcx_pkg::RTCX_SEL_INT_STATUS: begin
                rdata_nxt[`RTCX_INT_W-1:0] = int_status_r;
            end
            rtcx_pkg::RTCX_SEL_INT_MASK: begin
                rdata_nxt[`RTCX_INT_W-1:0] = int_mask_r;
            end
        endcase
    end

    // No wait state: the answer is prepared in the setup cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= setup_ph;
            pslverr <= setup_ph && (sel == rtcx_pkg::RTCX_SEL_NONE);
            prdata <= (setup_ph && !pwrite) ? rdata_nxt : 32'h0000_0000;
        end
    end

    // Clock control bits written by software.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_r <= 1'b0;
            alarm_en_r <= 1'b0;
            auto_reset_r <= 1'b0;
        end else if (wr_en && sel == rtcx_pkg::RTCX_SEL_CTRL && pstrb[0]) begin
            run_r <= pwdata[`RTCX_CTRL_RUN_BIT];
            alarm_en_r <= pwdata[`RTCX_CTRL_ALARM_EN_BIT];
            auto_reset_r <= pwdata[`RTCX_CTRL_ALARM_BIT];
        end
    end

    // Requests wait for the next slow tick; a written 0 never cancels one.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            load_req_r <= 1'b0;
            snap_req_r <= 1'b0;
        end else begin
            if (wr_en && sel == rtcx_pkg::RTCX_SEL_CTRL && pstrb[0] && pwdata[`RTCX_CTRL_LOAD_BIT]) begin
                load_req_r <= 1'b1;
            end else if (slow_tick) begin
                load_req_r <= 1'b0;
            end
            if (wr_en && sel == rtcx_pkg::RTCX_SEL_CTRL && pstrb[0] && pwdata[`RTCX_CTRL_SNAP_BIT]) begin
                snap_req_r <= 1'b1;
            end else if (slow_tick) begin
                snap_req_r <= 1'b0;
            end
        end
    end

    assign alarm_hit = slow_tick && alarm_en_r && run_r && (timer_r == alarm_r);

    // Timer: a pending load wins over counting and over the alarm reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_r <= '0;
        end else if (slow_tick && load_req_r) begin
            timer_r <= TIMER_W'({capture_r[3], capture_r[2], capture_r[1], capture_r[0]});
        end else if (alarm_hit && auto_reset_r) begin
            timer_r <= '0;
        end else if (slow_tick && run_r) begin
            timer_r <= timer_r + TIMER_W'(1);
        end
    end

    // Capture bytes; a snapshot overrides a software write in the same cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capture_r <= '{default: 8'h00};
        end else if (slow_tick && snap_req_r) begin
            for (int i = 0; i < 4; i++) begin
                capture_r[i] <= 8'(32'(timer_r) >> (8 * i));
            end
        end else if (wr_en && sel == rtcx_pkg::RTCX_SEL_CAPTURE && pstrb[0]) begin
            capture_r[idx[1:0]] <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alarm_r <= '0;
        end else if (wr_en && sel == rtcx_pkg::RTCX_SEL_ALARM) begin
            for (int b = 0; b < 4; b++) begin
                if (pstrb[b] && (8 * b) < TIMER_W) begin
                    alarm_r[8*b +: 8] <= pwdata[8*b +: 8];
                end
            end
        end
    end

    // The flag rises on a match and falls at the next slow tick.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alarm_event_flag <= 1'b0;
        end else if (slow_tick) begin
            alarm_event_flag <= alarm_hit;
        end
    end

    // Oscillator control register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_gain_ctrl_enable <= 1'b0;
            osc_mode_select <= 1'b0;
            osc_bias_double <= 1'b0;
        end else if (wr_en && sel == rtcx_pkg::RTCX_SEL_OSC_CTRL && pstrb[0]) begin
            osc_gain_ctrl_enable <= pwdata[`RTCX_XCN_GAIN_BIT];
            osc_mode_select <= pwdata[`RTCX_XCN_MODE_BIT];
            osc_bias_double <= pwdata[`RTCX_XCN_BIAS_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_valid_r <= 1'b0;
        end else begin
            osc_valid_r <= osc_amp_ok;
        end
    end

    // Oscillator configuration register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            load_cap_autostep_r <= 1'b0;
            load_cap_value_r <= LOAD_CAP_RESET;
        end else if (wr_en && sel == rtcx_pkg::RTCX_SEL_OSC_CFG && pstrb[0]) begin
            load_cap_autostep_r <= pwdata[`RTCX_XCF_STEP_BIT];
            load_cap_value_r <= pwdata[`RTCX_XCF_CAP_MSB:0];
        end
    end

    // With stepping on, the applied value moves one code per slow tick.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            load_cap_now <= LOAD_CAP_RESET;
        end else if (!load_cap_autostep_r) begin
            load_cap_now <= load_cap_value_r;
        end else if (slow_tick && load_cap_now != load_cap_value_r) begin
            load_cap_now <= (load_cap_now < load_cap_value_r) ? load_cap_now + 4'h1 : load_cap_now - 4'h1;
        end
    end

    // Interrupt events; a new event wins over the read that clears.
    always_comb begin
        int_set = '0;
        int_set[`RTCX_INT_ALARM_BIT] = alarm_hit;
        int_set[`RTCX_INT_LOAD_BIT] = slow_tick && load_req_r;
        int_set[`RTCX_INT_SNAP_BIT] = slow_tick && snap_req_r;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_status_r <= '0;
        end else if (rd_en && sel == rtcx_pkg::RTCX_SEL_INT_STATUS) begin
            int_status_r <= int_set;
        end else begin
            int_status_r <= int_status_r | int_set;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_mask_r <= '0;
        end else if (wr_en && sel == rtcx_pkg::RTCX_SEL_INT_MASK && pstrb[0]) begin
            int_mask_r <= pwdata[`RTCX_INT_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(int_status_r & int_mask_r);
        end
    end
endmodule

// file: sim/rtcx_ctrl_chk.sv
`timescale 1ns/1ps
module rtcx_ctrl_chk #(
    parameter int SLOW_DIV = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic osc_amp_ok,
    input wire logic osc_gain_ctrl_enable,
    input wire logic osc_mode_select,
    input wire logic osc_bias_double,
    input wire logic [3:0] load_cap_now,
    input wire logic alarm_event_flag,
    input wire logic irq
);
    logic [7:0] hi_cnt_r;
    logic osc_wr;
    logic rd_done;
    assign osc_wr = psel && penable && pready && pwrite && paddr == 12'h014;
    assign rd_done = pready && !pwrite;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Counts how long the alarm flag has been high without a break.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hi_cnt_r <= 8'h00;
        end else begin
            hi_cnt_r <= alarm_event_flag ? hi_cnt_r + 8'h01 : 8'h00;
        end
    end
    ready_after_setup_a:
        assert property (pready |-> psel && penable && $past(psel && !penable)) else $error("stray pready");
    ready_single_a:
        assert property (pready |=> !pready) else $error("pready too long");
    unmapped_err_a:
        assert property (pready && paddr == 12'h030 |-> pslverr && prdata == 32'h0) else $error("no pslverr");
    gain_write_a:
        assert property (osc_wr && pstrb[0] |=> osc_gain_ctrl_enable == $past(pwdata[7])) else $error("gain bit");
    mode_write_a:
        assert property (osc_wr && pstrb[0] |=> osc_mode_select == $past(pwdata[6])) else $error("mode bit");
    bias_write_a:
        assert property (osc_wr && pstrb[0] |=> osc_bias_double == $past(pwdata[5])) else $error("bias bit");
    lane_guard_a:
        assert property (osc_wr && !pstrb[0] |=> $stable({osc_gain_ctrl_enable, osc_mode_select, osc_bias_double}))
        else $error("lane ignored");
    osc_low_zero_a:
        assert property (rd_done && paddr == 12'h014 |-> prdata[3:0] == 4'h0) else $error("osc low bits");
    osc_valid_read_a:
        assert property (rd_done && paddr == 12'h014 |-> prdata[4] == $past(osc_amp_ok)
            || prdata[4] == $past(osc_amp_ok, 2)) else $error("amp valid");
    cfg_unused_zero_a:
        assert property (rd_done && paddr == 12'h018 |-> prdata[5:4] == 2'b00) else $error("cfg unused");
    alarm_read_a:
        assert property (rd_done && paddr == 12'h010 |-> prdata[2] == alarm_event_flag
            || prdata[2] == $past(alarm_event_flag)) else $error("alarm read");
    alarm_flag_short_a:
        assert property (hi_cnt_r <= 8'(SLOW_DIV)) else $error("alarm flag too long");
endmodule

// file: sim/rtcx_ctrl_tb_top.sv
`timescale 1ns/1ps
module rtcx_ctrl_tb_top;
    logic pclk, presetn, psel, penable, pwrite, osc_amp_ok, pready, pslverr, err;
    logic osc_gain_ctrl_enable, osc_mode_select, osc_bias_double, alarm_event_flag, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, v;
    logic [3:0] pstrb, load_cap_now;
    logic [7:0] w;
    integer seed, fails, compares, n, i;
    rtcx_ctrl #(.SLOW_DIV(8)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .osc_amp_ok(osc_amp_ok), .osc_gain_ctrl_enable(osc_gain_ctrl_enable),
        .osc_mode_select(osc_mode_select), .osc_bias_double(osc_bias_double),
        .load_cap_now(load_cap_now), .alarm_event_flag(alarm_event_flag), .irq(irq));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task stop_test;
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t mismatch got %h exp %h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] exp_osc(input logic [7:0] wd, input logic amp);
        return {24'h0, wd[7:5], amp, 4'h0};
    endfunction
    // One APB transfer; holds the request until pready is seen at an edge.
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && k < 20) begin
            k++;
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20) begin
            fails++;
            stop_test();
        end
    endtask
    task rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, 4'hf);
        chk(rd, exp);
    endtask
    // Polls the control register until the given request bit drops.
    task poll(input int b);
        n = 0;
        do begin
            apb(1'b0, 12'h010, 32'h0, 4'hf);
            n++;
        end while (rd[b] !== 1'b0 && n < 12);
        chk({31'h0, rd[b]}, 32'h0);
    endtask
    initial begin
        seed = 57;
        fails = 0;
        compares = 0;
        {presetn, psel, penable, pwrite, osc_amp_ok, paddr, pwdata, pstrb} = '0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(12'h014, 32'h00);
        rdchk(12'h018, 32'h40);
        for (i = 0; i < 6; i++) begin
            v = $random(seed);
            w = (i == 0) ? 8'hff : v[7:0];
            osc_amp_ok <= v[8];
            apb(1'b1, 12'h014, {24'h0, w}, 4'hf);
            rdchk(12'h014, exp_osc(w, v[8]));
            chk({29'h0, osc_gain_ctrl_enable, osc_mode_select, osc_bias_double}, {29'h0, w[7:5]});
        end
        apb(1'b1, 12'h014, ~{24'h0, w}, 4'he);
        chk({29'h0, osc_gain_ctrl_enable, osc_mode_select, osc_bias_double}, {29'h0, w[7:5]});
        apb(1'b1, 12'h018, 32'h3a, 4'hf);
        rdchk(12'h018, 32'h4a);
        chk({28'h0, load_cap_now}, 32'ha);
        apb(1'b1, 12'h018, 32'h8d, 4'hf);
        rdchk(12'h018, 32'h8d);
        repeat (40) @(posedge pclk);
        rdchk(12'h018, 32'hcd);
        chk({28'h0, load_cap_now}, 32'hd);
        apb(1'b0, 12'h030, 32'h0, 4'hf);
        chk({31'h0, err}, 32'h1);
        v = {2'b10, 30'($random(seed))};
        for (i = 0; i < 4; i++) apb(1'b1, 12'(i * 4), {24'h0, v[i*8+:8]}, 4'hf);
        apb(1'b1, 12'h010, 32'h02, 4'hf);
        poll(1);
        for (i = 0; i < 4; i++) apb(1'b1, 12'(i * 4), 32'h0, 4'hf);
        apb(1'b1, 12'h010, 32'h01, 4'hf);
        poll(0);
        for (i = 0; i < 4; i++) rdchk(12'(i * 4), {24'h0, v[i*8+:8]});
        apb(1'b1, 12'h020, v + 32'h2, 4'hf);
        apb(1'b1, 12'h010, 32'h1c, 4'hf);
        n = 0;
        while (alarm_event_flag !== 1'b1 && n < 80) begin
            @(posedge pclk);
            n++;
        end
        chk({31'h0, alarm_event_flag}, 32'h1);
        repeat (7) @(posedge pclk);
        chk({31'h0, alarm_event_flag}, 32'h1);
        @(posedge pclk);
        chk({31'h0, alarm_event_flag}, 32'h0);
        rdchk(12'h010, 32'h18);
        repeat (3) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, 12'h044, 32'h1, 4'hf);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        rdchk(12'h040, 32'h7);
        rdchk(12'h040, 32'h0);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, 12'h010, 32'h01, 4'hf);
        poll(0);
        rdchk(12'h00c, 32'h0);
        stop_test();
    end
endmodule
bind rtcx_ctrl rtcx_ctrl_chk #(.SLOW_DIV(SLOW_DIV)) chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .osc_amp_ok(osc_amp_ok), .osc_gain_ctrl_enable(osc_gain_ctrl_enable),
    .osc_mode_select(osc_mode_select), .osc_bias_double(osc_bias_double), .load_cap_now(load_cap_now),
    .alarm_event_flag(alarm_event_flag), .irq(irq));
